// *** hdl/lsw_consts.vh ***
// Constants of the lamp switch serial control port: frame layout, register
// addresses, field positions, reset values and timing figures.
// Assumes a 200 MHz system clock; times are converted to cycles in the top.
`ifndef LSW_CONSTS_VH
`define LSW_CONSTS_VH

`define LSW_CLK_MHZ        200
`define LSW_FRAME_BITS     16
`define LSW_ADDR_MSB       15
`define LSW_ADDR_LSB       11
`define LSW_DATA_MSB       10
`define LSW_ADDR_W         5
`define LSW_DATA_W         11

`define LSW_ADDR_OUT       5'h01
`define LSW_ADDR_PWM       5'h02
`define LSW_ADDR_DUTY0     5'h03
`define LSW_ADDR_DUTY1     5'h04
`define LSW_ADDR_SENSE     5'h05
`define LSW_ADDR_WDOG      5'h06

`define LSW_OUT_ON0        0
`define LSW_OUT_ON1        1
`define LSW_OUT_DIRECT     2
`define LSW_PWM_EN         0
`define LSW_PWM_CLK_SEL    1
`define LSW_SNS_LSB        0
`define LSW_SNS_MSB        1
`define LSW_SNS_OFF        2'h0
`define LSW_DUTY_MSB       7
`define LSW_REG_RESET      11'h000

`define LSW_PWM_DIV        128
`define LSW_WDOG_US        10000
`define LSW_CLKFAIL_US     1000
`define LSW_INT_TICK_NS    65104
`define LSW_CLK_SETTLE_NS  100

`endif

// *** hdl/lsw_spi_shift.v ***
// Serial shift engine of the lamp switch control port.
// Assumes chip select, serial clock and data input are synchronous to clk.
`include "lsw_consts.vh"

module lsw_spi_shift #(
  parameter W = 16
) (
  // System
  input  wire         clk_sys_i,
  input  wire         rst_n_i,
  // Serial pins
  input  wire         chip_select_n_i,
  input  wire         sclk_i,
  input  wire         si_i,
  output reg          so_o,
  output reg          so_oe_o,
  // Status and frame
  input  wire [W-1:0] status_i,
  output reg          frame_valid_o,
  output reg  [W-1:0] frame_o
);

  reg         cs_n_q;
  reg         sclk_q;
  reg [W-1:0] tx_reg;
  reg [4:0]   cnt_reg;

  wire cs_fall = cs_n_q & ~chip_select_n_i;
  wire cs_rise = ~cs_n_q & chip_select_n_i;
  // Serial clock edges count only inside a frame.
  wire active  = ~chip_select_n_i & ~cs_n_q;
  wire sc_fall = active & sclk_q & ~sclk_i;
  wire sc_rise = active & ~sclk_q & sclk_i;

  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      cs_n_q        <= 1'b1;
      sclk_q        <= 1'b0;
      tx_reg        <= {W{1'b0}};
      cnt_reg       <= 5'h00;
      so_o          <= 1'b0;
      so_oe_o       <= 1'b0;
      frame_valid_o <= 1'b0;
      frame_o       <= {W{1'b0}};
    end else begin
      cs_n_q        <= chip_select_n_i;
      sclk_q        <= sclk_i;
      so_oe_o       <= ~chip_select_n_i;
      frame_valid_o <= 1'b0;
      if (cs_fall) begin
        tx_reg  <= status_i;
        so_o    <= status_i[W-1];
        cnt_reg <= 5'h00;
      end
      if (sc_fall) begin
        frame_o <= {frame_o[W-2:0], si_i};
        if (cnt_reg != 5'h1F)
          cnt_reg <= cnt_reg + 5'h01;
      end
      // The first rising edge precedes any sample, so the MSB stays put.
      if (sc_rise && cnt_reg != 5'h00) begin
        tx_reg <= {tx_reg[W-2:0], 1'b0};
        so_o   <= tx_reg[W-2];
      end
      if (cs_rise && cnt_reg == W)
        frame_valid_o <= 1'b1;
    end
  end

endmodule // lsw_spi_shift

// *** hdl/lsw_pwm.v ***
// One PWM channel: a period of DIV clock ticks and a programmed duty.
// Assumes tick_i is a one-cycle pulse in the system clock domain.
`include "lsw_consts.vh"

module lsw_pwm #(
  parameter DIV = 128
) (
  // System
  input  wire       clk_sys_i,
  input  wire       rst_n_i,
  // Control
  input  wire       enable_i,
  input  wire       tick_i,
  input  wire [7:0] duty_i,
  // Output
  output reg        pwm_o
);

  reg [6:0] phase_reg;

  always @(posedge clk_sys_i) begin
    if (!rst_n_i || !enable_i) begin
      phase_reg <= 7'h00;
      pwm_o     <= 1'b0;
    end else begin
      if (tick_i)
        phase_reg <= (phase_reg == DIV - 1) ? 7'h00 : phase_reg + 7'h01;
      // Duty 0 never turns on; DIV or more stays on for the whole period.
      pwm_o <= (duty_i >= DIV) | ({1'b0, phase_reg} < duty_i);
    end
  end

endmodule // lsw_pwm

// *** hdl/lsw_top.v ***
// Control logic of a dual high-side lamp switch behind its serial port.
// Assumes all pins are synchronous to clk_sys_i; analogue parts are outside.
//
// Contract
// - Chip select rise commits frame to register
// - Chip select fall loads status into shifter
// - Data output driven only while selected
// - Clock and data ignored while deselected
// - Sample on falling, shift on rising edge
// - Five-bit address selects target register
// - Reset input low clears registers, sleeps if nothing else wakes
// - Reset input rise starts the watchdog
// - Inputs, wake, clock, reset wake device
// - Direct pins switch their outputs
// - PWM period is clock divided by 128
// - Fault pin pulled low on any fault
// - Logic supply loss enters fail-safe
// - Sense selects current, temperature or off
// - Clock fail check only external, enabled
// - Duty zero off, full duty on
// - Sleep makes all settings read as zero
// - Status shifted out MSB first
`include "lsw_consts.vh"

module lsw_top #(
  parameter WDOG_CYC    = `LSW_WDOG_US * `LSW_CLK_MHZ,
  parameter CLKFAIL_CYC = `LSW_CLKFAIL_US * `LSW_CLK_MHZ,
  parameter INT_TICK_CYC = `LSW_INT_TICK_NS * `LSW_CLK_MHZ / 1000
) (
  // System
  input  wire       clk_sys_i,
  input  wire       resetn_i,
  // Serial port
  input  wire       chip_select_n_i,
  input  wire       sclk_i,
  input  wire       si_i,
  output wire       so_o,
  output wire       so_oe_o,
  // Device pins
  input  wire       reset_n_input_i,
  input  wire       wake_i,
  input  wire       direct_ctrl_0_i,
  input  wire       direct_ctrl_1_i,
  input  wire       pwm_clock_i,
  input  wire       vdd_fail_i,
  input  wire [3:0] fault_i,
  // Outputs
  output reg        power_out_0_o,
  output reg        power_out_1_o,
  output reg        fault_flag_n_o,
  output reg        fault_flag_n_oe_o,
  output reg  [1:0] sense_feedback_out_o,
  output reg        sense_feedback_out_oe_o,
  output reg        sleep_o,
  output reg        fail_safe_o
);

  localparam CLK_SETTLE_CYC = (`LSW_CLK_SETTLE_NS * `LSW_CLK_MHZ + 999) / 1000;
  localparam NREG = 32;

  // Register file indexed by the frame address.
  reg [`LSW_DATA_W-1:0] regs [0:NREG-1];

  reg        rstin_q;
  reg        wdog_run_reg;
  reg [31:0] wdog_cnt_reg;
  reg        wdog_to_reg;
  reg        ext_q;
  reg        pclk_q;
  reg [31:0] clkmon_reg;
  reg        clk_fail_reg;
  reg        clk_on_reg;
  reg [31:0] itick_reg;
  reg        itick_reg_p;

  wire        frame_valid;
  wire [15:0] frame;
  wire [15:0] status;
  wire        pwm0;
  wire        pwm1;

  wire [`LSW_ADDR_W-1:0] frm_addr = frame[`LSW_ADDR_MSB:`LSW_ADDR_LSB];
  wire [`LSW_DATA_W-1:0] frm_data = frame[`LSW_DATA_MSB:0];

  // Any wake source holds the device out of sleep.
  wire awake = reset_n_input_i | wake_i | direct_ctrl_0_i
             | direct_ctrl_1_i | clk_on_reg;

  // While asleep every setting behaves as zero.
  wire [`LSW_DATA_W-1:0] out_cfg  = awake ? regs[`LSW_ADDR_OUT]   : `LSW_REG_RESET;
  wire [`LSW_DATA_W-1:0] pwm_cfg  = awake ? regs[`LSW_ADDR_PWM]   : `LSW_REG_RESET;
  wire [`LSW_DATA_W-1:0] duty0    = awake ? regs[`LSW_ADDR_DUTY0] : `LSW_REG_RESET;
  wire [`LSW_DATA_W-1:0] duty1    = awake ? regs[`LSW_ADDR_DUTY1] : `LSW_REG_RESET;
  wire [`LSW_DATA_W-1:0] sns_cfg  = awake ? regs[`LSW_ADDR_SENSE] : `LSW_REG_RESET;

  wire pwm_en    = pwm_cfg[`LSW_PWM_EN];
  wire ext_sel   = ~pwm_cfg[`LSW_PWM_CLK_SEL];
  wire direct_en = out_cfg[`LSW_OUT_DIRECT];
  wire fail_now  = vdd_fail_i | wdog_to_reg;
  wire fault_any = (|fault_i) | clk_fail_reg;

  // External PWM clock arrives on direct input zero when selected.
  wire ext_clk  = direct_ctrl_0_i;
  wire ext_rise = ext_clk & ~ext_q;
  wire pclk_rise = pwm_clock_i & ~pclk_q;
  wire pwm_tick = ext_sel ? ext_rise : itick_reg_p;

  // Operating modes; sleep outranks fail-safe, which outranks a fault.
  localparam MODE_SLEEP  = 2'h0;
  localparam MODE_NORMAL = 2'h1;
  localparam MODE_SAFE   = 2'h2;
  localparam MODE_FAULT  = 2'h3;

  reg [1:0] mode_sel;

  always @* begin
    if (!awake)
      mode_sel = MODE_SLEEP;
    else if (fail_now)
      mode_sel = MODE_SAFE;
    else if (fault_any)
      mode_sel = MODE_FAULT;
    else
      mode_sel = MODE_NORMAL;
  end

  assign status = {fault_any, ~awake, fail_now, power_out_1_o, power_out_0_o,
                   direct_ctrl_1_i, direct_ctrl_0_i, wake_i, wdog_run_reg,
                   clk_fail_reg, fault_i, 2'h0};

  lsw_spi_shift #(
    .W (`LSW_FRAME_BITS)
  ) u_shift (
    .clk_sys_i       (clk_sys_i),
    .rst_n_i         (resetn_i),
    .chip_select_n_i (chip_select_n_i),
    .sclk_i          (sclk_i),
    .si_i            (si_i),
    .so_o            (so_o),
    .so_oe_o         (so_oe_o),
    .status_i        (status),
    .frame_valid_o   (frame_valid),
    .frame_o         (frame)
  );

  lsw_pwm #(
    .DIV (`LSW_PWM_DIV)
  ) u_pwm0 (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (resetn_i),
    .enable_i  (pwm_en),
    .tick_i    (pwm_tick),
    .duty_i    (duty0[`LSW_DUTY_MSB:0]),
    .pwm_o     (pwm0)
  );

  lsw_pwm #(
    .DIV (`LSW_PWM_DIV)
  ) u_pwm1 (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (resetn_i),
    .enable_i  (pwm_en),
    .tick_i    (pwm_tick),
    .duty_i    (duty1[`LSW_DUTY_MSB:0]),
    .pwm_o     (pwm1)
  );

  // Register writes; the reset pin clears everything while held low.
  // Addresses without a function still store their data.
  genvar g;
  generate
    for (g = 0; g < NREG; g = g + 1) begin : g_reg
      always @(posedge clk_sys_i) begin
        if (!resetn_i || !reset_n_input_i)
          regs[g] <= `LSW_REG_RESET;
        else if (frame_valid && frm_addr == g)
          regs[g] <= frm_data;
      end
    end
  endgenerate

  // Watchdog: started by the reset pin rising, kicked by each valid frame.
  always @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      rstin_q      <= 1'b0;
      wdog_run_reg <= 1'b0;
      wdog_cnt_reg <= 32'h0000_0000;
      wdog_to_reg  <= 1'b0;
    end else begin
      rstin_q <= reset_n_input_i;
      if (!reset_n_input_i) begin
        wdog_run_reg <= 1'b0;
        wdog_cnt_reg <= 32'h0000_0000;
        wdog_to_reg  <= 1'b0;
      end else if (!rstin_q) begin
        wdog_run_reg <= 1'b1;
        wdog_cnt_reg <= 32'h0000_0000;
      end else if (wdog_run_reg) begin
        // The timeout latches until the reset pin goes low; frames cannot clear it.
        if (frame_valid)
          wdog_cnt_reg <= 32'h0000_0000;
        else if (wdog_cnt_reg == WDOG_CYC - 1)
          wdog_to_reg <= 1'b1;
        else
          wdog_cnt_reg <= wdog_cnt_reg + 32'h0000_0001;
      end
    end
  end

  // Clock monitor: activity wakes; a stall counts as a fault when checked.
  always @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      ext_q        <= 1'b0;
      pclk_q       <= 1'b0;
      clkmon_reg   <= 32'h0000_0000;
      clk_fail_reg <= 1'b0;
      clk_on_reg   <= 1'b0;
    end else begin
      // Separate detectors, so a pin held high cannot mask the other's edges.
      ext_q  <= ext_clk;
      pclk_q <= pwm_clock_i;
      if (ext_rise || pclk_rise) begin
        clkmon_reg <= 32'h0000_0000;
        clk_on_reg <= 1'b1;
      end else if (clkmon_reg != CLKFAIL_CYC) begin
        clkmon_reg <= clkmon_reg + 32'h0000_0001;
      end else begin
        clk_on_reg <= 1'b0;
      end
      // A stalled external clock is a fault only while it is the PWM source.
      if (pwm_en && ext_sel && awake)
        clk_fail_reg <= (clkmon_reg == CLKFAIL_CYC) && (clkmon_reg > CLK_SETTLE_CYC);
      else
        clk_fail_reg <= 1'b0;
    end
  end

  // Internal PWM clock divider.
  always @(posedge clk_sys_i) begin
    if (!resetn_i || !pwm_en || ext_sel) begin
      itick_reg   <= 32'h0000_0000;
      itick_reg_p <= 1'b0;
    end else if (itick_reg == INT_TICK_CYC - 1) begin
      itick_reg   <= 32'h0000_0000;
      itick_reg_p <= 1'b1;
    end else begin
      itick_reg   <= itick_reg + 32'h0000_0001;
      itick_reg_p <= 1'b0;
    end
  end

  // Output drive, fault pin and sense selection.
  always @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      power_out_0_o           <= 1'b0;
      power_out_1_o           <= 1'b0;
      fault_flag_n_o          <= 1'b0;
      fault_flag_n_oe_o       <= 1'b0;
      sense_feedback_out_o    <= 2'h0;
      sense_feedback_out_oe_o <= 1'b0;
      sleep_o                 <= 1'b1;
      fail_safe_o             <= 1'b0;
    end else begin
      sleep_o     <= mode_sel == MODE_SLEEP;
      fail_safe_o <= mode_sel == MODE_SAFE;
      // In fail-safe the pins take over, since the host may be gone.
      case (mode_sel)
        MODE_SLEEP: begin
          power_out_0_o <= 1'b0;
          power_out_1_o <= 1'b0;
        end
        MODE_SAFE: begin
          power_out_0_o <= direct_ctrl_0_i;
          power_out_1_o <= direct_ctrl_1_i;
        end
        default: begin
          // Direct enable hands the outputs to the pins; faults do not gate them.
          if (direct_en) begin
            power_out_0_o <= direct_ctrl_0_i;
            power_out_1_o <= direct_ctrl_1_i;
          end else if (pwm_en) begin
            power_out_0_o <= pwm0 & ~fault_i[0];
            power_out_1_o <= pwm1 & ~fault_i[1];
          end else begin
            power_out_0_o <= out_cfg[`LSW_OUT_ON0] & ~fault_i[0];
            power_out_1_o <= out_cfg[`LSW_OUT_ON1] & ~fault_i[1];
          end
        end
      endcase
      fault_flag_n_o    <= 1'b0;
      fault_flag_n_oe_o <= fault_any;
      sense_feedback_out_o    <= sns_cfg[`LSW_SNS_MSB:`LSW_SNS_LSB];
      sense_feedback_out_oe_o <= sns_cfg[`LSW_SNS_MSB:`LSW_SNS_LSB] != `LSW_SNS_OFF;
    end
  end

endmodule // lsw_top

// *** verification/lsw_top_assertions.sv ***
// Checker of the lamp switch control port, bound to every lsw_top.
// Assumes one clock domain and the synchronous active-low reset.
module lsw_top_chk (
  // System
  input wire logic       clk_sys_i,
  input wire logic       resetn_i,
  // Watched pins
  input wire logic       chip_select_n_i,
  input wire logic       sclk_i,
  input wire logic       so_o,
  input wire logic       so_oe_o,
  input wire logic       reset_n_input_i,
  input wire logic       vdd_fail_i,
  input wire logic [3:0] fault_i,
  input wire logic       power_out_0_o,
  input wire logic       power_out_1_o,
  input wire logic       fault_flag_n_o,
  input wire logic       fault_flag_n_oe_o,
  input wire logic [1:0] sense_feedback_out_o,
  input wire logic       sense_feedback_out_oe_o,
  input wire logic       sleep_o,
  input wire logic       fail_safe_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  chk_so_float: assert property (
    chip_select_n_i && $past(chip_select_n_i) |-> !so_oe_o) else $error("so driven idle");
  chk_so_drive: assert property (
    $fell(chip_select_n_i) |=> so_oe_o) else $error("so not driven after select");
  chk_so_edge: assert property (
    !chip_select_n_i && !$past(chip_select_n_i, 2) && $changed(so_o)
    |-> $past(sclk_i) && !$past(sclk_i, 2)) else $error("so changed off a rising edge");
  chk_fault_low: assert property (
    reset_n_input_i && (|fault_i) |-> ##[1:3] fault_flag_n_oe_o) else $error("fault not flagged");
  chk_fault_level: assert property (
    fault_flag_n_oe_o |-> !fault_flag_n_o) else $error("fault pin driven high");
  chk_vdd_safe: assert property (
    reset_n_input_i && vdd_fail_i |-> ##[1:3] fail_safe_o) else $error("no fail-safe");
  chk_sleep_off: assert property (
    sleep_o && $past(sleep_o) |-> !power_out_0_o && !power_out_1_o) else $error("on in sleep");
  chk_reset_wake: assert property (
    $rose(reset_n_input_i) |-> ##[1:3] !sleep_o) else $error("reset rise did not wake");
  chk_reset_clear: assert property (
    (!reset_n_input_i) [*3] |-> !sense_feedback_out_oe_o) else $error("sense kept in reset");
  chk_sense_oe: assert property (
    sense_feedback_out_oe_o == (sense_feedback_out_o != 2'h0)) else $error("sense enable wrong");
endmodule // lsw_top_chk

bind lsw_top lsw_top_chk u_lsw_top_chk (.clk_sys_i, .resetn_i, .chip_select_n_i, .sclk_i,
  .so_o, .so_oe_o, .reset_n_input_i, .vdd_fail_i, .fault_i, .power_out_0_o, .power_out_1_o,
  .fault_flag_n_o, .fault_flag_n_oe_o, .sense_feedback_out_o, .sense_feedback_out_oe_o,
  .sleep_o, .fail_safe_o);

// *** verification/lsw_host.sv ***
// Host microcontroller model: serial bus master of the lamp switch port.
// Assumes the clock runs at 200 MHz; each serial clock phase lasts 4 cycles.
module lsw_host (
  // System
  input  wire logic clk_sys_i,
  // Serial pins
  input  wire logic so_i,
  output logic      chip_select_n_o,
  output logic      sclk_o,
  output logic      si_o
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int GAP = 200;
  initial begin
    chip_select_n_o = 1'b1;
    sclk_o = 1'b0;
    si_o = 1'b0;
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  // Sends nfall bits of w and collects the bits seen on so at each fall.
  task automatic xfer(input logic [15:0] w, input int nfall, output logic [15:0] rx);
    rx = 16'h0000;
    step(1);
    chip_select_n_o = 1'b0;
    step(4);
    for (int i = 0; i < nfall; i++) begin
      sclk_o = 1'b1;
      si_o = w[15 - (i % 16)];
      step(4);
      rx = {rx[14:0], so_i};
      sclk_o = 1'b0;
      step(4);
    end
    si_o = 1'b0;
    chip_select_n_o = 1'b1;
    step(GAP);
  endtask
  // Toggles clock and data while deselected, ending with the clock low.
  task automatic junk(input int n);
    for (int i = 0; i < n; i++) begin
      sclk_o = ~sclk_o;
      si_o = ~si_o;
      step(2);
    end
    sclk_o = 1'b0;
    si_o = 1'b0;
    step(2);
  endtask
endmodule // lsw_host

// *** verification/lsw_top_tb.sv ***
// Self-checking bench of lsw_top with the host model on the serial port.
// Assumes shortened watchdog, clock-fail and internal tick counts.
module lsw_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int WDOG = 3000;
  logic clk = 1'b0, rstn = 1'b0, rpin = 1'b0, wake = 1'b0, in0 = 1'b0, in1 = 1'b0;
  logic pclk = 1'b0, vfail = 1'b0, so, so_oe, out0, out1, ff_n, ff_oe, sns_oe, slp, fsafe;
  logic cs_n, sclk, si;
  logic [3:0] flt = 4'h0;
  logic [1:0] sns, prev;
  logic [15:0] rx, rnd = 16'hC779, cnt;
  int fail_count = 0, tests_run = 0;
  wire so_w = so_oe ? so : 1'bz;
  always #2.5 clk = ~clk;
  lsw_host u_lsw_host (.clk_sys_i(clk), .so_i(so_w), .chip_select_n_o(cs_n), .sclk_o(sclk),
    .si_o(si));
  lsw_top #(.WDOG_CYC(WDOG), .CLKFAIL_CYC(100), .INT_TICK_CYC(4)) u_lsw_top (
    .clk_sys_i(clk), .resetn_i(rstn), .chip_select_n_i(cs_n), .sclk_i(sclk), .si_i(si),
    .so_o(so), .so_oe_o(so_oe), .reset_n_input_i(rpin), .wake_i(wake), .direct_ctrl_0_i(in0),
    .direct_ctrl_1_i(in1), .pwm_clock_i(pclk), .vdd_fail_i(vfail), .fault_i(flt),
    .power_out_0_o(out0), .power_out_1_o(out1), .fault_flag_n_o(ff_n),
    .fault_flag_n_oe_o(ff_oe), .sense_feedback_out_o(sns), .sense_feedback_out_oe_o(sns_oe),
    .sleep_o(slp), .fail_safe_o(fsafe));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [10:0] d);
    u_lsw_host.xfer({a, d}, 16, rx);
  endtask
  task automatic restart();
    rpin = 1'b0;
    tick(2000);
    rpin = 1'b1;
    tick(1000);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    fail_count++;
    conclude();
  end
  initial begin
    tick(8);
    rstn = 1'b1;
    tick(2);
    check("sleep", slp, 1'b1);
    for (int k = 0; k < 4; k++) begin
      {pclk, in1, in0, wake} = 4'h1 << k;
      tick(4);
      check("awake", slp, 1'b0);
      {pclk, in1, in0, wake} = 4'h0;
      tick(150);
      check("asleep", slp, 1'b1);
    end
    restart();
    u_lsw_host.xfer(16'h0000, 16, rx);
    check("status", rx, 16'h0080);
    prev = 2'h0;
    for (int i = 0; i < 12; i++) begin
      rnd = lfsr(rnd);
      wr(rnd[2] ? 5'h07 : 5'h01, {rnd[12:5], 1'b0, rnd[1:0]});
      check("readback", rx[12:11], prev);
      if (!rnd[2])
        prev = rnd[1:0];
      check("outputs", {out1, out0}, prev);
    end
    for (int n = 15; n <= 17; n += 2) begin
      u_lsw_host.xfer({5'h01, 9'h000, ~prev}, n, rx);
      check("odd frame", {out1, out0}, prev);
    end
    u_lsw_host.junk(40);
    check("idle junk", {out1, out0}, prev);
    wr(5'h01, 11'h004);
    for (int k = 0; k < 4; k++) begin
      {in1, in0} = k[1:0];
      tick(2);
      check("direct", {out1, out0}, k[1:0]);
    end
    {in1, in0} = 2'h0;
    for (int s = 0; s < 4; s++) begin
      wr(5'h05, s[10:0]);
      check("sense", {sns_oe, sns}, {s != 0, s[1:0]});
    end
    wr(5'h01, 11'h003);
    wr(5'h02, 11'h003);
    for (int k = 0; k < 3; k++) begin
      wr(5'h03, k == 0 ? 11'h000 : (k == 1 ? 11'h080 : 11'h040));
      cnt = 16'h0000;
      repeat (512) begin
        tick(1);
        cnt = cnt + out0;
      end
      check("duty", cnt, k == 0 ? 16'h0000 : (k == 1 ? 16'h0200 : 16'h0100));
    end
    tick(150);
    check("no clock fail", ff_oe, 1'b0);
    wr(5'h02, 11'h001);
    tick(150);
    check("clock fail", ff_oe, 1'b1);
    cnt = 16'h0000;
    for (int i = 0; i < 1024; i++) begin
      in0 = i[1];
      tick(1);
      if (i >= 512)
        cnt = cnt + out0;
    end
    check("ext duty", cnt, 16'h0100);
    check("clock back", ff_oe, 1'b0);
    in0 = 1'b0;
    restart();
    flt = rnd[3:0] | 4'h1;
    tick(4);
    check("fault pin", {ff_oe, ff_n}, 2'h2);
    u_lsw_host.xfer(16'h0000, 16, rx);
    check("fault bits", {rx[15], rx[5:2]}, {1'b1, flt});
    flt = 4'h0;
    vfail = 1'b1;
    in0 = 1'b1;
    tick(4);
    check("fail safe", {fsafe, out0}, 2'h3);
    vfail = 1'b0;
    in0 = 1'b0;
    restart();
    tick(WDOG - 1100);
    check("watchdog early", fsafe, 1'b0);
    tick(200);
    check("watchdog late", fsafe, 1'b1);
    conclude();
  end
endmodule // lsw_top_tb
